// File: rtl/ssr_defines.svh
// Constants for the sector set/reset distribution block.
// Assumes inclusion by the package, the design file and the testbench.
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
`define SSR_CELLS_PER_SECTOR 4
`define SSR_ADDR_CTRL 32'h0000_0000
`define SSR_ADDR_SRC_SEL 32'h0000_0004
`define SSR_ADDR_INV 32'h0000_0008
`define SSR_ADDR_CELL_FN 32'h0000_000c
`define SSR_ADDR_CELL_Q 32'h0000_0010
`define SSR_ADDR_STATUS 32'h0000_0014
`define SSR_CTRL_LOADED_BIT 0
`define SSR_RESET_WORD 32'h0000_0000
`define SSR_POWERUP_Q 1'b1
`define SSR_ACTIVE_LEVEL 1'b0
`define SSR_HTRANS_NONSEQ 2'b10
`endif

// File: rtl/ssr_pkg.sv
// Types for the sector set/reset distribution block.
// Assumes ssr_defines.svh is on the include path.
package ssr_pkg;
`include "ssr_defines.svh"
   typedef struct packed {
      logic sel;
      logic write;
      logic [31:0] addr;
   } ahb_req_t;
   typedef enum logic [0:0] {
      SRC_GLOBAL = 1'b0,
      SRC_EXPRESS = 1'b1
   } sector_src_t;
   typedef enum logic [0:0] {
      FN_SET = 1'b0,
      FN_CLEAR = 1'b1
   } cell_fn_t;
endpackage

// File: rtl/sector_set_reset_distribution.sv
// Sector set/reset distribution: one global net, per-sector source mux and
// polarity stage, per-cell set/clear function, registers with clocked set/reset ahead of data.
// Assumes an AHB-Lite master on clk_i; pins arrive unsynchronised.
`include "ssr_defines.svh"
module sector_set_reset_distribution #(
   parameter int COLS = 4,
   parameter int SECTORS = 2
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic global_sr_pin_i,
   input wire logic [COLS*SECTORS-1:0] express_bus_i,
   input wire logic [COLS*SECTORS*`SSR_CELLS_PER_SECTOR-1:0] cell_d_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [COLS*SECTORS*`SSR_CELLS_PER_SECTOR-1:0] cell_q_o
);
   import ssr_pkg::*;
   localparam int NS = COLS * SECTORS;
   localparam int NC = NS * `SSR_CELLS_PER_SECTOR;

   // Single global net, synchronised before use
   // Reset to the inactive level, so no false set/reset follows reset
   logic gsr_meta_reg;
   logic gsr_sync_reg;
   logic [NS-1:0] exp_meta_reg;
   logic [NS-1:0] exp_sync_reg;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         gsr_meta_reg <= 1'b1;
         gsr_sync_reg <= 1'b1;
         exp_meta_reg <= '1;
         exp_sync_reg <= '1;
      end else if (ce_i) begin
         gsr_meta_reg <= global_sr_pin_i;
         gsr_sync_reg <= gsr_meta_reg;
         exp_meta_reg <= express_bus_i;
         exp_sync_reg <= exp_meta_reg;
      end
   end

   // Configuration registers
   logic loaded_reg;
   logic [NS-1:0] src_sel_reg;
   logic [NS-1:0] inv_reg;
   logic [NC-1:0] cell_fn_reg;
   ahb_req_t req_reg;

   // Word transfers only: the size qualifier is not decoded
   wire logic take = hsel_i && hready_i && (htrans_i == `SSR_HTRANS_NONSEQ);
   wire logic wr_ctrl = req_reg.sel && req_reg.write && (req_reg.addr == `SSR_ADDR_CTRL);
   // Static once loaded: further writes to the selects are ignored
   wire logic cfg_open = !loaded_reg;
   wire logic wr_src = req_reg.sel && req_reg.write && cfg_open
      && (req_reg.addr == `SSR_ADDR_SRC_SEL);
   wire logic wr_inv = req_reg.sel && req_reg.write && cfg_open
      && (req_reg.addr == `SSR_ADDR_INV);
   wire logic wr_fn = req_reg.sel && req_reg.write && cfg_open
      && (req_reg.addr == `SSR_ADDR_CELL_FN);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         req_reg <= '0;
      end else if (ce_i) begin
         req_reg <= '{sel: take, write: hwrite_i, addr: haddr_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         loaded_reg <= 1'b0;
         src_sel_reg <= '0;
         inv_reg <= '0;
         cell_fn_reg <= '0;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            loaded_reg <= hwdata_i[`SSR_CTRL_LOADED_BIT];
         end
         if (wr_src) begin
            src_sel_reg <= hwdata_i[NS-1:0];
         end
         if (wr_inv) begin
            inv_reg <= hwdata_i[NS-1:0];
         end
         if (wr_fn) begin
            cell_fn_reg <= hwdata_i[NC-1:0];
         end
      end
   end

   // Per sector: global net fans to every column, mux, polarity
   logic [NS-1:0] sector_sr;
   genvar s;
   generate
      for (s = 0; s < NS; s++) begin : g_sector
         wire logic raw = (src_sel_reg[s] == SRC_EXPRESS) ? exp_sync_reg[s] : gsr_sync_reg;
         assign sector_sr[s] = raw ^ inv_reg[s];
         // Checked against the pins two synchroniser edges earlier
         a_sector_inv: assert property (@(posedge clk_i) disable iff (reset_i)
            ($past(ce_i) && $past(ce_i, 2) && !$past(reset_i) && !$past(reset_i, 2)
               && (src_sel_reg[s] == SRC_GLOBAL))
            |-> (sector_sr[s] == ($past(global_sr_pin_i, 2) ^ inv_reg[s])))
            else $error("sector polarity wrong on global source");
         a_express_path: assert property (@(posedge clk_i) disable iff (reset_i)
            ($past(ce_i) && $past(ce_i, 2) && !$past(reset_i) && !$past(reset_i, 2)
               && (src_sel_reg[s] == SRC_EXPRESS))
            |-> (sector_sr[s] == ($past(express_bus_i[s], 2) ^ inv_reg[s])))
            else $error("sector polarity wrong on express source");
      end
   endgenerate

   // Cell registers; the set/reset acts in the same cycle as it is seen,
   // ahead of data, modelling the asynchronous action on the sampled net.
   logic [NC-1:0] q_reg;
   wire logic [NC-1:0] sr_force;
   wire logic [NC-1:0] sr_fval;
   genvar c;
   generate
      for (c = 0; c < NC; c++) begin : g_cell
         assign sr_force[c] = loaded_reg
            && (sector_sr[c / `SSR_CELLS_PER_SECTOR] == `SSR_ACTIVE_LEVEL);
         assign sr_fval[c] = (cell_fn_reg[c] == FN_SET);
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               q_reg[c] <= `SSR_POWERUP_Q;
            end else if (ce_i) begin
               if (!loaded_reg) begin
                  q_reg[c] <= `SSR_POWERUP_Q;
               end else if (sr_force[c]) begin
                  q_reg[c] <= sr_fval[c];
               end else begin
                  q_reg[c] <= cell_d_i[c];
               end
            end
         end
         // Once loaded, an inactive (high) set/reset leaves the register to its data
         a_idle_follows: assert property (@(posedge clk_i) disable iff (reset_i)
            (ce_i && loaded_reg && !sr_force[c]) |=> (q_reg[c] == $past(cell_d_i[c])))
            else $error("cell register ignored its data");
      end
   endgenerate

   // Output also forced while the set/reset is active, so it does not lag the cell register by an edge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cell_q_o <= '1;
      end else if (ce_i) begin
         for (int i = 0; i < NC; i++) begin
            cell_q_o[i] <= sr_force[i] ? sr_fval[i] : q_reg[i];
         end
      end
   end
   a_out_forced: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && sr_force[0]) |=> (cell_q_o[0] == $past(cell_fn_reg[0] == FN_SET)))
      else $error("cell 0 output not forced");
   // Clock enable low holds every output where it stands
   a_freeze_outputs: assert property (@(posedge clk_i) disable iff (reset_i)
      !ce_i |=> ($stable(cell_q_o) && $stable(hrdata_o)))
      else $error("outputs moved while clock enable low");

   // Read decode
   wire logic [31:0] rd_mux =
      (haddr_i == `SSR_ADDR_CTRL) ? {31'h0, loaded_reg} :
      (haddr_i == `SSR_ADDR_SRC_SEL) ? 32'(src_sel_reg) :
      (haddr_i == `SSR_ADDR_INV) ? 32'(inv_reg) :
      (haddr_i == `SSR_ADDR_CELL_FN) ? 32'(cell_fn_reg) :
      (haddr_i == `SSR_ADDR_CELL_Q) ? 32'(q_reg) :
      (haddr_i == `SSR_ADDR_STATUS) ? {30'h0, gsr_sync_reg, loaded_reg} :
      `SSR_RESET_WORD;
   // Zero wait states: the slave never stretches a transfer
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hrdata_o <= `SSR_RESET_WORD;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else if (ce_i) begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         if (take && !hwrite_i) begin
            hrdata_o <= rd_mux;
         end
      end
   end

   a_powerup_high: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && !loaded_reg) |=> (q_reg == '1))
      else $error("register not high before configuration");
   // Selects only move while the load bit is clear
   a_cfg_static: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(loaded_reg)) |-> $stable(src_sel_reg) && $stable(inv_reg))
      else $error("configuration changed after load");
   a_cell_sr: assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && loaded_reg && sr_force[0]) |=> (q_reg[0] == $past(cell_fn_reg[0] == FN_SET)))
      else $error("cell 0 did not take set/reset value");
   // Never a wait state or an error response
   a_ready_okay: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 (hreadyout_o && !hresp_o))
      else $error("bus response not OKAY");
endmodule

// File: test/sr_pin_model.sv
// Pin-side model of the user I/O that drives the reset sources.
// Assumes requests change right after rising edges of clk_i.
module sr_pin_model (
   input wire logic clk_i,
   input wire logic g_req_i,
   input wire logic [7:0] ex_req_i,
   output logic global_sr_pin_o,
   output logic [7:0] express_bus_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial global_sr_pin_o = 1'b1;
   initial express_bus_o = 8'hff;
   // General user pin only; clock pins never carry the global net
   always @(posedge clk_i) global_sr_pin_o <= g_req_i;
   always @(posedge clk_i) express_bus_o <= ex_req_i;
endmodule

// File: test/tb_top.sv
// Self-checking bench for the sector set/reset distribution block.
// Assumes the pin model drives the global net and express bus.
`include "ssr_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ssr_pkg::*;
   logic clk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, rd_phase = 0, g_req = 1, ce = 1;
   logic [31:0] held;
   logic [1:0] htrans_i = 2'h0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, cell_d_i = 32'h0, hrdata_o, cell_q_o, fn;
   logic [7:0] ex_req = 8'hff, express_bus_i, sel, inv;
   logic global_sr_pin_i, hreadyout_o, hresp_o;
   logic [31:0] exp_q[$];
   int fail_count = 0, compares = 0, seed = 32'h6cd5;
   always #25 clk_i = ~clk_i;
   sr_pin_model u_pins(.clk_i(clk_i), .g_req_i(g_req), .ex_req_i(ex_req),
      .global_sr_pin_o(global_sr_pin_i), .express_bus_o(express_bus_i));
   sector_set_reset_distribution u_dut(.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
      .global_sr_pin_i(global_sr_pin_i), .express_bus_i(express_bus_i), .cell_d_i(cell_d_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cell_q_o(cell_q_o));
   task automatic final_report();
      if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_q(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t cell_q got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) begin
         n++;
         if (n > 40) begin
            fail_count++;
            final_report();
         end
         @(posedge clk_i);
      end
   endtask
   // For reads, d is the expected word, checked by the watcher
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      htrans_i <= `SSR_HTRANS_NONSEQ;
      haddr_i <= a;
      hwrite_i <= wr;
      wait_rdy();
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      rd_phase <= !wr;
      if (!wr) exp_q.push_back(d);
      wait_rdy();
      rd_phase <= 1'b0;
   endtask
   always @(posedge clk_i)
      if (rd_phase === 1'b1 && hreadyout_o === 1'b1) check(hrdata_o, exp_q.pop_front());
   // Forced cells take ~fn; others follow their data
   function automatic logic [31:0] model_q(input logic [31:0] d);
      logic [31:0] r;
      logic src;
      for (int c = 0; c < 32; c++) begin
         src = (sel[c/4] ? ex_req[c/4] : g_req) ^ inv[c/4];
         r[c] = src ? d[c] : ~fn[c];
      end
      return r;
   endfunction
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      check_q(cell_q_o, 32'hffffffff);
      bus(1'b0, `SSR_ADDR_CELL_Q, 32'hffffffff);
      bus(1'b0, `SSR_ADDR_STATUS, 32'h2);
      bus(1'b1, 32'h20, 32'h5a5a5a5a);
      bus(1'b0, 32'h20, 32'h0);
      sel = 8'($random(seed));
      inv = 8'($random(seed));
      fn = $random(seed);
      bus(1'b1, `SSR_ADDR_SRC_SEL, {24'h0, sel});
      bus(1'b1, `SSR_ADDR_INV, {24'h0, inv});
      bus(1'b1, `SSR_ADDR_CELL_FN, fn);
      bus(1'b1, `SSR_ADDR_CTRL, 32'h1);
      bus(1'b1, `SSR_ADDR_SRC_SEL, {24'h0, ~sel});
      bus(1'b0, `SSR_ADDR_SRC_SEL, {24'h0, sel});
      repeat (12) begin
         g_req <= 1'($random(seed));
         ex_req <= 8'($random(seed));
         cell_d_i <= $random(seed);
         repeat (5) @(posedge clk_i);
         bus(1'b0, `SSR_ADDR_CELL_Q, model_q(cell_d_i));
      end
      // Clock enable low freezes the outputs whatever the inputs do
      ce <= 1'b0;
      @(posedge clk_i);
      held = cell_q_o;
      g_req <= ~g_req;
      ex_req <= ~ex_req;
      cell_d_i <= ~cell_d_i;
      repeat (4) @(posedge clk_i);
      check_q(cell_q_o, held);
      ce <= 1'b1;
      bus(1'b1, `SSR_ADDR_CTRL, 32'h0);
      // Cells return to 1 one edge after the load bit clears
      @(posedge clk_i);
      bus(1'b0, `SSR_ADDR_CELL_Q, 32'hffffffff);
      // Mid-run reset while loaded wipes the configuration
      bus(1'b1, `SSR_ADDR_CTRL, 32'h1);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      bus(1'b0, `SSR_ADDR_SRC_SEL, 32'h0);
      bus(1'b0, `SSR_ADDR_CELL_Q, 32'hffffffff);
      final_report();
   end
endmodule
